/* File: core/remote_rx_pkg.sv */
package remote_rx_pkg;
   // Register byte offsets
   localparam logic [11:0] OFS_RECEIVE_ON = 12'h004;
   localparam logic [11:0] OFS_LOW_WORD = 12'h008;
   localparam logic [11:0] OFS_MID_WORD = 12'h00c;
   localparam logic [11:0] OFS_TOP_BYTE = 12'h010;
   localparam logic [11:0] OFS_LEADER_LIMITS = 12'h014;
   localparam logic [11:0] OFS_RX_CONTROL = 12'h018;
   localparam logic [11:0] OFS_RX_STATUS = 12'h024;
   localparam logic [11:0] OFS_FS_SELECT = 12'h034;
   // Field positions
   localparam int CMAX_LSB = 24;
   localparam int CMIN_LSB = 16;
   localparam int LMAX_LSB = 8;
   localparam int LMIN_LSB = 0;
   localparam int THRESH_LSB = 0;
   localparam int GAP_LSB = 8;
   localparam int LEADER_OPT_BIT = 25;
   localparam int ST_DONE_BIT = 8;
   localparam int ST_LEADER_BIT = 9;
   localparam int ST_OVERFLOW_BIT = 10;
   localparam int ST_BUSY_BIT = 11;
   // Reset values
   localparam logic [31:0] LEADER_LIMITS_RST = 32'h00000000;
   localparam logic [7:0] THRESH_RST = 8'h00;
   localparam logic [7:0] GAP_RST = 8'hff;
   localparam logic [7:0] TOP_BYTE_RST = 8'h00;
   // Sizes and timing
   localparam int STORE_BITS = 72;
   localparam int COUNT_W = 7;
   localparam int MEAS_W = 10;
   localparam logic [1:0] FS_DIV_LAST = 2'h3;
   localparam int FIFO_DEPTH = 8;
   typedef enum logic [1:0] {ST_WAIT, ST_DATA, ST_SKIP} rxState_t;
endpackage

/* File: core/bit_fifo.sv */
`timescale 1ns/1ps
module bit_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 8
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW:0] wrPtr_q;
   logic [PW:0] rdPtr_q;
   logic full;
   logic empty;

   assign empty = (wrPtr_q == rdPtr_q);
   assign full = (wrPtr_q[PW-1:0] == rdPtr_q[PW-1:0]) && (wrPtr_q[PW] != rdPtr_q[PW]);
   assign inReady = !full;
   assign outValid = !empty;
   assign outData = mem_q[rdPtr_q[PW-1:0]];

   always_ff @(posedge core_clk) begin
      if (inValid && !full) begin
         mem_q[wrPtr_q[PW-1:0]] <= inData;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
      end else begin
         if (inValid && !full) begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (outReady && !empty) begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
      end
   end
endmodule

/* File: core/cycle_meter.sv */
`timescale 1ns/1ps
module cycle_meter #(
   parameter int W = 10
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic run,
   input wire logic unitTick,
   input wire logic lineIn,
   input wire logic [7:0] gapLimit,
   output logic cycleDone,
   output logic [W-1:0] periodUnits,
   output logic [W-1:0] lowUnits,
   output logic gapDone
);
   logic linePrev_q;
   logic active_q;
   logic [W-1:0] per_q;
   logic [W-1:0] low_q;
   logic fall;
   logic gapHit;

   assign fall = linePrev_q && !lineIn;
   assign gapHit = active_q && (per_q > {{(W-8){1'b0}}, gapLimit});

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         linePrev_q <= 1'b1;
      end else begin
         linePrev_q <= lineIn;
      end
   end

   // A cycle runs from one falling edge to the next
   always_ff @(posedge core_clk) begin
      if (!nrst || !run) begin
         active_q <= 1'b0;
         per_q <= '0;
         low_q <= '0;
         cycleDone <= 1'b0;
         gapDone <= 1'b0;
         periodUnits <= '0;
         lowUnits <= '0;
      end else begin
         cycleDone <= 1'b0;
         gapDone <= 1'b0;
         if (fall) begin
            active_q <= 1'b1;
            cycleDone <= active_q;
            periodUnits <= per_q;
            lowUnits <= low_q;
            per_q <= '0;
            low_q <= '0;
         end else if (gapHit) begin
            // Silence ends the frame; the last open cycle is dropped
            active_q <= 1'b0;
            gapDone <= 1'b1;
         end else if (active_q && unitTick) begin
            // Saturate so a long pulse never wraps into a short one
            if (per_q != '1) begin
               per_q <= per_q + 1'b1;
            end
            if (!lineIn && low_q != '1) begin
               low_q <= low_q + 1'b1;
            end
         end
      end
   end
endmodule

/* File: core/remote_rx_leader_detect.sv */
`timescale 1ns/1ps
module remote_rx_leader_detect
   import remote_rx_pkg::*;
#(
   parameter int FIFO_W = 2,
   parameter int FIFO_D = remote_rx_pkg::FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic remoteIn,
   input wire logic lowSpeedClk,
   input wire logic timerOut,
   output logic frameReady
);
   import remote_rx_pkg::*;

   logic receiveOn_q;
   logic [31:0] leaderLimits_q;
   logic leaderOptional_q;
   logic [7:0] thresh_q;
   logic [7:0] gap_q;
   logic fsSelect_q;
   logic fsPrev_q;
   logic [1:0] fsDiv_q;
   rxState_t state_q;
   logic leaderSeen_q;
   logic overflow_q;
   logic [STORE_BITS-1:0] store_q;
   logic [COUNT_W-1:0] storeCnt_q;
   logic fresh_q;
   logic frameDone_q;

   logic setup;
   logic access;
   logic wrAccess;
   logic rdAccess;
   logic hit;
   logic [31:0] rdMux;
   logic fsLevel;
   logic fsTick;
   logic unitTick;
   logic cycleDone;
   logic gapDone;
   logic [MEAS_W-1:0] periodUnits;
   logic [MEAS_W-1:0] lowUnits;
   logic [MEAS_W-1:0] cmax;
   logic [MEAS_W-1:0] cmin;
   logic [MEAS_W-1:0] lmax;
   logic [MEAS_W-1:0] lmin;
   logic periodOk;
   logic lowOk;
   logic leaderOk;
   logic shortFirst;
   logic dataBit;
   logic pushValid;
   logic pushReady;
   logic [FIFO_W-1:0] pushData;
   logic popValid;
   logic popReady;
   logic [FIFO_W-1:0] popData;
   logic popBit;
   logic popEnd;
   logic lowWordRead;

   // Bus decode
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign wrAccess = access && pwrite;
   assign rdAccess = access && !pwrite;
   assign pready = 1'b1;
   assign pslverr = access && !hit;

   always_comb begin
      hit = 1'b1;
      rdMux = 32'h00000000;
      if (paddr == OFS_RECEIVE_ON) begin
         rdMux = {31'h0, receiveOn_q};
      end else if (paddr == OFS_LOW_WORD) begin
         rdMux = store_q[31:0];
      end else if (paddr == OFS_MID_WORD) begin
         rdMux = store_q[63:32];
      end else if (paddr == OFS_TOP_BYTE) begin
         rdMux = {24'h0, store_q[71:64]};
      end else if (paddr == OFS_LEADER_LIMITS) begin
         rdMux = leaderLimits_q;
      end else if (paddr == OFS_RX_CONTROL) begin
         rdMux[LEADER_OPT_BIT] = leaderOptional_q;
         rdMux[GAP_LSB+:8] = gap_q;
         rdMux[THRESH_LSB+:8] = thresh_q;
      end else if (paddr == OFS_RX_STATUS) begin
         rdMux[COUNT_W-1:0] = storeCnt_q;
         rdMux[ST_DONE_BIT] = frameDone_q;
         rdMux[ST_LEADER_BIT] = leaderSeen_q;
         rdMux[ST_OVERFLOW_BIT] = overflow_q;
         rdMux[ST_BUSY_BIT] = (state_q != ST_WAIT);
      end else if (paddr == OFS_FS_SELECT) begin
         rdMux = {31'h0, fsSelect_q};
      end else begin
         hit = 1'b0;
      end
   end

   // Read data is captured in the setup cycle so it stands through access
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         prdata <= 32'h00000000;
      end else if (setup) begin
         prdata <= rdMux;
      end
   end

   // Writable settings; limits are only sampled by the receiver's compare
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         receiveOn_q <= 1'b0;
         leaderLimits_q <= LEADER_LIMITS_RST;
         leaderOptional_q <= 1'b0;
         thresh_q <= THRESH_RST;
         gap_q <= GAP_RST;
         fsSelect_q <= 1'b0;
      end else if (wrAccess) begin
         if (paddr == OFS_RECEIVE_ON) begin
            receiveOn_q <= pwdata[0];
         end else if (paddr == OFS_LEADER_LIMITS) begin
            leaderLimits_q <= pwdata;
         end else if (paddr == OFS_RX_CONTROL) begin
            leaderOptional_q <= pwdata[LEADER_OPT_BIT];
            gap_q <= pwdata[GAP_LSB+:8];
            thresh_q <= pwdata[THRESH_LSB+:8];
         end else if (paddr == OFS_FS_SELECT) begin
            fsSelect_q <= pwdata[0];
         end
      end
   end

   // Sampling clock choice and the divide-by-four unit
   assign fsLevel = fsSelect_q ? timerOut : lowSpeedClk;
   assign fsTick = fsLevel && !fsPrev_q;
   assign unitTick = fsTick && (fsDiv_q == FS_DIV_LAST);

   always_ff @(posedge core_clk) begin
      if (!nrst || !receiveOn_q) begin
         fsPrev_q <= 1'b0;
         fsDiv_q <= 2'h0;
      end else begin
         fsPrev_q <= fsLevel;
         if (fsTick) begin
            fsDiv_q <= fsDiv_q + 2'h1;
         end
      end
   end

   cycle_meter #(
      .W(MEAS_W)
   ) u_meter (
      .core_clk(core_clk),
      .nrst(nrst),
      .run(receiveOn_q),
      .unitTick(unitTick),
      .lineIn(remoteIn),
      .gapLimit(gap_q),
      .cycleDone(cycleDone),
      .periodUnits(periodUnits),
      .lowUnits(lowUnits),
      .gapDone(gapDone)
   );

   // Leader qualification on the first cycle
   assign cmax = {2'b00, leaderLimits_q[CMAX_LSB+:8]};
   assign cmin = {2'b00, leaderLimits_q[CMIN_LSB+:8]};
   assign lmax = {2'b00, leaderLimits_q[LMAX_LSB+:8]};
   assign lmin = {2'b00, leaderLimits_q[LMIN_LSB+:8]};
   assign periodOk = (periodUnits <= cmax) && (periodUnits > cmin);
   // Zero max low width means a high-only leader, low limits unused
   assign lowOk = (lmax == '0) || ((lowUnits <= lmax) && (lowUnits > lmin));
   assign leaderOk = periodOk && lowOk;
   assign shortFirst = (periodUnits <= cmin);
   assign dataBit = (periodUnits > {2'b00, thresh_q});

   always_comb begin
      pushValid = 1'b0;
      pushData = {1'b0, dataBit};
      case (state_q)
         ST_WAIT: begin
            if (cycleDone) begin
               if (cmax == '0) begin
                  pushValid = 1'b1;
               end else if (!leaderOk && leaderOptional_q && shortFirst) begin
                  pushValid = 1'b1;
               end
            end
         end
         ST_DATA: begin
            if (cycleDone) begin
               pushValid = 1'b1;
            end else if (gapDone) begin
               pushValid = 1'b1;
               pushData = {1'b1, 1'b0};
            end
         end
         default: begin
            pushValid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!nrst || !receiveOn_q) begin
         state_q <= ST_WAIT;
      end else begin
         case (state_q)
            ST_WAIT: begin
               if (cycleDone) begin
                  // Only the first cycle of a frame meets the limits
                  if (cmax == '0) begin
                     state_q <= ST_DATA;
                  end else if (leaderOk) begin
                     state_q <= ST_DATA;
                  end else if (leaderOptional_q && shortFirst) begin
                     state_q <= ST_DATA;
                  end else begin
                     state_q <= ST_SKIP;
                  end
               end
            end
            ST_DATA: begin
               if (gapDone) begin
                  state_q <= ST_WAIT;
               end
            end
            default: begin
               if (gapDone) begin
                  state_q <= ST_WAIT;
               end
            end
         endcase
      end
   end

   // Sticky status; hardware set wins over a clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         leaderSeen_q <= 1'b0;
         overflow_q <= 1'b0;
      end else begin
         if (state_q == ST_WAIT && cycleDone && cmax != '0 && leaderOk) begin
            leaderSeen_q <= 1'b1;
         end else if (wrAccess && paddr == OFS_RX_STATUS && pwdata[ST_LEADER_BIT]) begin
            leaderSeen_q <= 1'b0;
         end
         if (pushValid && !pushReady) begin
            overflow_q <= 1'b1;
         end else if (wrAccess && paddr == OFS_RX_STATUS && pwdata[ST_OVERFLOW_BIT]) begin
            overflow_q <= 1'b0;
         end
      end
   end

   bit_fifo #(
      .WIDTH(FIFO_W),
      .DEPTH(FIFO_D)
   ) u_fifo (
      .core_clk(core_clk),
      .nrst(nrst),
      .inValid(pushValid),
      .inReady(pushReady),
      .inData(pushData),
      .outValid(popValid),
      .outReady(popReady),
      .outData(popData)
   );

   // Draining stalls while a finished frame waits to be read
   assign popReady = !frameDone_q;
   assign popBit = popValid && popReady && !popData[1];
   assign popEnd = popValid && popReady && popData[1];
   assign lowWordRead = rdAccess && paddr == OFS_LOW_WORD;
   assign frameReady = frameDone_q;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         store_q <= {TOP_BYTE_RST, 64'h0};
         storeCnt_q <= '0;
         fresh_q <= 1'b1;
      end else if (popBit) begin
         if (fresh_q) begin
            store_q <= {{(STORE_BITS-1){1'b0}}, popData[0]};
            storeCnt_q <= 7'd1;
            fresh_q <= 1'b0;
         end else if (storeCnt_q < 7'(STORE_BITS)) begin
            // New bit enters at bit 0, older bits move up
            store_q <= {store_q[STORE_BITS-2:0], popData[0]};
            storeCnt_q <= storeCnt_q + 7'd1;
         end
      end else if (popEnd) begin
         fresh_q <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         frameDone_q <= 1'b0;
      end else if (popEnd) begin
         frameDone_q <= 1'b1;
      end else if (lowWordRead) begin
         frameDone_q <= 1'b0;
      end
   end
endmodule

/* File: verif/remote_rx_properties.sv */
`timescale 1ns/1ps
module remote_rx_properties
   import remote_rx_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic frameReady
);
   logic [31:0] lim_q;
   wire acc = psel && penable;
   wire lowRd = acc && !pwrite && paddr == OFS_LOW_WORD;
   wire onWr = acc && pwrite && paddr == OFS_RECEIVE_ON;
   wire mapped = paddr inside {OFS_RECEIVE_ON, OFS_LOW_WORD, OFS_MID_WORD, OFS_TOP_BYTE,
      OFS_LEADER_LIMITS, OFS_RX_CONTROL, OFS_RX_STATUS, OFS_FS_SELECT};
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // Shadow copy, so read-back is judged without trusting the design
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         lim_q <= LEADER_LIMITS_RST;
      end else if (acc && pwrite && paddr == OFS_LEADER_LIMITS) begin
         lim_q <= pwdata;
      end
   end
   sequence doneRead;
      lowRd && frameReady;
   endsequence
   sequence doneKept;
      frameReady && !lowRd && !onWr;
   endsequence
   chk_ready_high:
      assert property (pready) else $error("pready low");
   chk_err_unmapped:
      assert property (acc && !mapped |-> pslverr) else $error("no error on unmapped");
   chk_err_mapped:
      assert property (acc && mapped |-> !pslverr) else $error("error on mapped");
   chk_top_byte:
      assert property (acc && !pwrite && paddr == OFS_TOP_BYTE |-> prdata[31:8] == 24'h0)
      else $error("top byte wider than a byte");
   chk_limits_read:
      assert property (acc && !pwrite && paddr == OFS_LEADER_LIMITS |-> prdata == lim_q)
      else $error("limits read-back differs");
   chk_reset_idle:
      assert property ($rose(nrst) |-> prdata == 32'h0 && !frameReady)
      else $error("outputs busy after reset");
   chk_done_clear:
      assert property (doneRead |=> !frameReady) else $error("frame done not cleared");
   chk_frame_hold:
      assert property (doneKept |=> frameReady) else $error("frame done dropped");
   chk_err_idle:
      assert property (!acc |-> !pslverr) else $error("error outside access");
endmodule

bind remote_rx_leader_detect remote_rx_properties chk (.core_clk(core_clk), .nrst(nrst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .frameReady(frameReady));

/* File: verif/remote_line_model.sv */
`timescale 1ns/1ps
module remote_line_model (
   input wire logic core_clk,
   output logic remoteIn,
   output logic lowSpeedClk,
   output logic timerOut
);
   logic [1:0] div_q = 2'h0;
   initial begin
      remoteIn = 1'b1;
      lowSpeedClk = 1'b0;
      timerOut = 1'b0;
   end
   // Oscillator runs free, one fs period is four core clocks
   always @(posedge core_clk) begin
      div_q <= div_q + 2'h1;
      lowSpeedClk <= div_q[1];
      timerOut <= div_q[0];
   end
   // Line idles high; one unit is four fs periods
   task automatic cycle(input int lowU, input int highU);
      remoteIn <= 1'b0;
      repeat (16 * lowU) @(posedge core_clk);
      remoteIn <= 1'b1;
      repeat (16 * highU) @(posedge core_clk);
   endtask
endmodule

/* File: verif/remote_rx_leader_detect_test.sv */
`timescale 1ns/1ps
module remote_rx_leader_detect_test;
   import remote_rx_pkg::*;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, remoteIn, lowSpeedClk, timerOut, frameReady;
   logic [32:0] expQ[$];
   logic [71:0] store;
   logic [71:0] keep;
   logic [31:0] v;
   int bad_count = 0;
   int n_tests = 0;
   int cycles = 0;
   int seed = 32'h3976;
   int lows[4] = '{6, 10, 2, 5};
   int highs[4] = '{18, 5, 12, 4};
   always #10 core_clk = ~core_clk;
   remote_rx_leader_detect dut (.core_clk(core_clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .remoteIn(remoteIn), .lowSpeedClk(lowSpeedClk),
      .timerOut(timerOut), .frameReady(frameReady));
   remote_line_model line (.core_clk(core_clk), .remoteIn(remoteIn),
      .lowSpeedClk(lowSpeedClk), .timerOut(timerOut));
   task automatic check(input logic [32:0] seen, input logic [32:0] want);
      n_tests++;
      if (seen !== want) begin
         bad_count++;
         $display("[ERR] %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic e);
      expQ.push_back({e, d});
      apb(1'b0, a, 32'h0);
   endtask
   // Every finished read is judged against the oldest note
   always @(posedge core_clk) begin
      if (psel && penable && !pwrite && pready) begin
         check({pslverr, prdata}, expQ.pop_front());
      end
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         bad_count++;
         end_of_test();
      end
   end
   task automatic setup(input logic [31:0] lim, input logic [31:0] ctl);
      apb(1'b1, OFS_RECEIVE_ON, 32'h0);
      apb(1'b1, OFS_LEADER_LIMITS, lim);
      apb(1'b1, OFS_RX_CONTROL, ctl);
      apb(1'b1, OFS_RECEIVE_ON, 32'h1);
   endtask
   task automatic frame(input int lowU, input int highU, input int n);
      logic b;
      if (lowU > 0) begin
         line.cycle(lowU, highU);
      end
      for (int i = 0; i < n; i++) begin
         v = $random(seed);
         b = v[0];
         // Earliest bit ends highest; LSB-first users reverse it themselves
         store = {store[70:0], b};
         line.cycle(1, b ? 5 : 1);
      end
      line.cycle(1, 0);
   endtask
   task automatic wait_done(input logic want);
      for (int i = 0; i < 1500 && frameReady !== 1'b1; i++) @(posedge core_clk);
      check({32'h0, frameReady}, {32'h0, want});
   endtask
   task automatic rd_store;
      rd(OFS_TOP_BYTE, {24'h0, store[71:64]}, 1'b0);
      rd(OFS_MID_WORD, store[63:32], 1'b0);
      rd(OFS_LOW_WORD, store[31:0], 1'b0);
   endtask
   initial begin
      repeat (6) @(posedge core_clk);
      nrst <= 1'b1;
      rd(OFS_LEADER_LIMITS, LEADER_LIMITS_RST, 1'b0);
      rd(OFS_TOP_BYTE, {24'h0, TOP_BYTE_RST}, 1'b0);
      rd(12'h100, 32'h0, 1'b1);
      v = $random(seed);
      apb(1'b1, OFS_LEADER_LIMITS, v);
      rd(OFS_LEADER_LIMITS, v, 1'b0);
      apb(1'b1, OFS_TOP_BYTE, 32'hff);
      rd(OFS_TOP_BYTE, 32'h0, 1'b0);
      $display("registers done");
      setup(32'h140a0803, 32'h00001403);
      store = 72'h0;
      frame(6, 9, 72);
      wait_done(1'b1);
      rd_store();
      $display("full frame done");
      keep = store;
      // Each case breaks one limit: long period, long low, short low, short period
      for (int i = 0; i < 4; i++) begin
         frame(lows[i], highs[i], 3);
         store = keep;
         wait_done(1'b0);
      end
      rd_store();
      $display("rejects done");
      setup(32'h140a0803, 32'h02001403);
      store = 72'h0;
      frame(0, 0, 9);
      wait_done(1'b1);
      rd_store();
      $display("optional leader done");
      setup(32'h00000803, 32'h00001403);
      store = 72'h0;
      frame(0, 0, 12);
      wait_done(1'b1);
      rd_store();
      $display("no leader done");
      setup(32'h140a0000, 32'h00001403);
      apb(1'b1, OFS_RX_STATUS, 32'h00000200);
      store = 72'h0;
      frame(15, 2, 7);
      wait_done(1'b1);
      // Seven bits, frame done, and a leader seen since the flag was cleared
      rd(OFS_RX_STATUS, 32'h00000307, 1'b0);
      rd_store();
      $display("high-only leader done");
      // Timer output doubles the unit rate, so only long cycles pass threshold 7
      apb(1'b1, OFS_FS_SELECT, 32'h1);
      rd(OFS_FS_SELECT, 32'h1, 1'b0);
      setup(32'h00000000, 32'h00001407);
      store = 72'h0;
      frame(0, 0, 10);
      wait_done(1'b1);
      rd_store();
      $display("timer clock done");
      end_of_test();
   end
endmodule
